// File: design/fes_params.svh
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define FES_OPC_WR_EN      8'h06
`define FES_OPC_WR_DIS     8'h04
`define FES_OPC_ERASE_A    8'h60
`define FES_OPC_ERASE_B    8'hc7
`define FES_OPC_SLEEP      8'hb9
`define FES_OPC_WAKE_ID    8'hab
`define FES_OPC_MAKER_ID   8'h90
`define FES_OPC_IDENT      8'h9f
`define FES_OPC_UID        8'h4b
`define FES_OPC_SUSPEND    8'h75
`define FES_OPC_RESUME     8'h7a
`define FES_OPC_RST_EN     8'h66
`define FES_OPC_RST        8'h99
`define FES_OPC_SRW_A      8'h01
`define FES_OPC_SRW_B      8'h31
`define FES_OPC_SRW_C      8'h11
`define FES_OPC_SEC_ERS    8'h44
`define FES_OPC_SEC_PRG    8'h42
`define FES_OPC_ERS_4K     8'h20
`define FES_OPC_ERS_32K    8'h52
`define FES_OPC_ERS_64K    8'hd8
`define FES_OPC_PAGE_A     8'h02
`define FES_OPC_PAGE_B     8'h32

// ----------------------------------------
// frame layout
// ----------------------------------------
`define FES_BITS_OPC       6'h08
`define FES_OPC_LAST       6'h07
`define FES_HDR_ADDR       6'h20
`define FES_HDR_UID        6'h28
`define FES_BITCNT_MAX     6'h3f
`define FES_LAST_WAKE      7'h07
`define FES_LAST_MAKER     7'h0f
`define FES_LAST_IDENT     7'h17
`define FES_ID_MSB         7'h7f
`define FES_PROT_ALL       3'h7
`define FES_PIN_CS         0
`define FES_PIN_SCLK       1
`define FES_PIN_SI         2
`define FES_PIN_RST        3'h1
`define FES_TMR_W          32
`define FES_TMR_ONE        32'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define FES_CLK_MHZ        50
`define FES_SLEEP_NS       3000
`define FES_WAKE_NS        3000
`define FES_SUS_NS         20000
`define FES_RESUME_NS      200
`define FES_ERASE_ALL_US   20000
`define FES_PROG_US        600
`define FES_SECT_US        45000
`define FES_SLEEP_CYC  ((`FES_SLEEP_NS*`FES_CLK_MHZ+999)/1000)
`define FES_WAKE_CYC   ((`FES_WAKE_NS*`FES_CLK_MHZ+999)/1000)
`define FES_SUS_CYC    ((`FES_SUS_NS*`FES_CLK_MHZ)/1000)
`define FES_RESUME_CYC ((`FES_RESUME_NS*`FES_CLK_MHZ)/1000)
`define FES_ERASE_ALL_CYC (`FES_ERASE_ALL_US*`FES_CLK_MHZ)
`define FES_PROG_CYC   (`FES_PROG_US*`FES_CLK_MHZ)
`define FES_SECT_CYC   (`FES_SECT_US*`FES_CLK_MHZ)

`endif

// File: design/fes_pkg.sv
package fes_pkg;

   // ----------------------------------------
   // operation sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      FES_IDLE       = 3'h0,
      FES_BUSY       = 3'h1,
      FES_SUSPENDING = 3'h3,
      FES_SUSPENDED  = 3'h2,
      FES_RESUMING   = 3'h6
   } fes_state_t;

   // ----------------------------------------
   // kind of self-timed operation
   // ----------------------------------------
   typedef enum logic [1:0] {
      FES_OPK_NONE = 2'h0,
      FES_OPK_PROG = 2'h1,
      FES_OPK_SECT = 2'h2,
      FES_OPK_CHIP = 2'h3
   } fes_opk_t;

endpackage : fes_pkg

// File: design/fes_pin_sync.sv
`timescale 1ns/1ps
`include "fes_params.svh"

module fes_pin_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // raw pins
   input  wire logic csN,
   input  wire logic sclk,
   input  wire logic si,
   // synchronised view
   output logic      csLvlN,
   output logic      siLvl,
   output logic      sclkRise,
   output logic      sclkFall,
   output logic      csFall,
   output logic      csRise
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] prev_q;

   // ----------------------------------------
   // two-stage synchroniser, then edge stage
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_q <= `FES_PIN_RST;
         sync_q <= `FES_PIN_RST;
         prev_q <= `FES_PIN_RST;
      end else begin
         meta_q <= {si, sclk, csN};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign csLvlN   = sync_q[`FES_PIN_CS];
   assign siLvl    = sync_q[`FES_PIN_SI];
   assign sclkRise = sync_q[`FES_PIN_SCLK] & ~prev_q[`FES_PIN_SCLK];
   assign sclkFall = ~sync_q[`FES_PIN_SCLK] & prev_q[`FES_PIN_SCLK];
   assign csFall   = ~sync_q[`FES_PIN_CS] & prev_q[`FES_PIN_CS];
   assign csRise   = sync_q[`FES_PIN_CS] & ~prev_q[`FES_PIN_CS];

endmodule : fes_pin_sync

// File: design/fes_timer.sv
`timescale 1ns/1ps
`include "fes_params.svh"

module fes_timer (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  reset,
   // control
   input  wire logic                  load,
   input  wire logic [`FES_TMR_W-1:0] loadVal,
   input  wire logic                  run,
   // status
   output logic                       done,
   output logic                       busy
);
   logic [`FES_TMR_W-1:0] cnt_q;

   // ----------------------------------------
   // down counter, holds while run is low
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= loadVal;
      end else if (run && busy) begin
         cnt_q <= cnt_q - `FES_TMR_ONE;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = run && !load && (cnt_q == `FES_TMR_ONE);

endmodule : fes_timer

// File: design/fes_cmd_core.sv
`timescale 1ns/1ps
`include "fes_params.svh"

// How it works
// [RULE1] 60h and c7h both erase whole array
// [RULE2] whole erase needs write enable latch set
// [RULE3] erase only if frame ends after bit eight
// [RULE4] erase sets busy flag, clears enable latch
// [RULE5] erase only when protection fully off
// [RULE6] b9h frame enters sleep after delay
// [RULE7] sleeping device takes only wake, reset
// [RULE8] sleep command refused while cycle runs
// [RULE9] reset leaves device in standby
// [RULE10] abh wakes; commands refused during delay
// [RULE11] abh after dummies streams device id
// [RULE12] abh ignored while busy flag set
// [RULE13] 90h plus address gives maker, device
// [RULE14] 9fh streams maker, type, capacity bytes
// [RULE15] 9fh not decoded while busy
// [RULE16] 4bh plus address, dummy gives uid
// [RULE17] suspend only during program or erase
// [RULE18] suspend flag now, busy clears later
// [RULE19] program suspend refuses listed commands
// [RULE20] erase suspend refuses listed commands
// [RULE21] resume clears flag, busy returns quickly
// [RULE22] 66h then 99h resets volatile state
// [RULE23] bits msb first on rising clock edge
module fes_cmd_core
   import fes_pkg::*;
#(
   parameter int unsigned    ERASE_ALL_CYC = `FES_ERASE_ALL_CYC,
   parameter int unsigned    PROG_CYC      = `FES_PROG_CYC,
   parameter int unsigned    SECT_CYC      = `FES_SECT_CYC,
   // identity values, arbitrary
   parameter logic [7:0]     MAKER_ID      = 8'h5a,
   parameter logic [7:0]     DEVICE_ID     = 8'h3c,
   parameter logic [7:0]     MEM_TYPE      = 8'h41,
   parameter logic [7:0]     CAPACITY      = 8'h17,
   parameter logic [127:0]   UNIQUE_ID     =
      128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // serial pins
   input  wire logic        csN,
   input  wire logic        sclk,
   input  wire logic        si,
   output logic             so,
   output logic             soOe,
   // protection settings
   input  wire logic [2:0]  protectRangeBits,
   input  wire logic        protectComplement,
   // other self-timed operations
   input  wire logic        extOpStart,
   input  wire logic        extOpIsProg,
   // frame decode for other logic
   output logic [7:0]       frameOpcode,
   output logic             frameOpcodeValid,
   output logic             frameRefused,
   // status
   output logic             writeInProgressFlag,
   output logic             writeEnableLatch,
   output logic [1:0]       suspendFlags,
   output logic             deepSleep,
   output logic             wakeBusy,
   output logic             chipEraseGo
);

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned SLEEP_CYC  = `FES_SLEEP_CYC;
   localparam int unsigned WAKE_CYC   = `FES_WAKE_CYC;
   localparam int unsigned SUS_CYC    = `FES_SUS_CYC;
   localparam int unsigned RESUME_CYC = `FES_RESUME_CYC;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic        csLvlN;
   logic        siLvl;
   logic        sclkRise;
   logic        sclkFall;
   logic        csFall;
   logic        csRise;
   logic [5:0]  bitCnt_q;
   logic [6:0]  shift_q;
   logic [7:0]  opcode_q;
   logic        opValid_q;
   logic [6:0]  outIdx_q;
   logic        so_q;
   logic        soOe_q;
   logic        wel_q;
   logic        deepSleep_q;
   logic        sleepPend_q;
   logic        wakeBusy_q;
   logic        rstArmed_q;
   fes_state_t  state_q;
   fes_state_t  state_d;
   fes_opk_t    kind_q;
   fes_opk_t    kind_d;
   logic        opDone;
   logic        dlyDone;
   logic        opLoad;
   logic        dlyLoad;
   logic [31:0] opLoadVal;
   logic [31:0] dlyLoadVal;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   fes_pin_sync uSync (
      .mclk     (mclk),
      .reset    (reset),
      .csN      (csN),
      .sclk     (sclk),
      .si       (si),
      .csLvlN   (csLvlN),
      .siLvl    (siLvl),
      .sclkRise (sclkRise),
      .sclkFall (sclkFall),
      .csFall   (csFall),
      .csRise   (csRise)
   );

   // ----------------------------------------
   // frame capture
   // ----------------------------------------
   wire rise     = sclkRise & ~csLvlN;
   wire fall     = sclkFall & ~csLvlN;
   wire cntFull  = (bitCnt_q == `FES_BITCNT_MAX);
   wire lastOpc  = (bitCnt_q == `FES_OPC_LAST);
   wire [5:0] bitCntInc = bitCnt_q + 6'h01;

   always_ff @(posedge mclk) begin
      if (reset || csFall) begin
         bitCnt_q  <= '0;
         shift_q   <= '0;
         opcode_q  <= '0;
         opValid_q <= 1'b0;
      end else if (rise) begin
         bitCnt_q <= cntFull ? bitCnt_q : bitCntInc;
         shift_q  <= {shift_q[5:0], siLvl}; // [RULE23]
         if (lastOpc) begin
            opcode_q  <= {shift_q, siLvl};
            opValid_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // opcode decode
   // ----------------------------------------
   wire isEraseAll = (opcode_q == `FES_OPC_ERASE_A) |
                     (opcode_q == `FES_OPC_ERASE_B); // [RULE1]
   wire isWrEn     = (opcode_q == `FES_OPC_WR_EN);
   wire isWrDis    = (opcode_q == `FES_OPC_WR_DIS);
   wire isSleep    = (opcode_q == `FES_OPC_SLEEP);
   wire isWakeId   = (opcode_q == `FES_OPC_WAKE_ID);
   wire isMakerId  = (opcode_q == `FES_OPC_MAKER_ID);
   wire isIdent    = (opcode_q == `FES_OPC_IDENT);
   wire isUid      = (opcode_q == `FES_OPC_UID);
   wire isSusp     = (opcode_q == `FES_OPC_SUSPEND);
   wire isRes      = (opcode_q == `FES_OPC_RESUME);
   wire isRstEn    = (opcode_q == `FES_OPC_RST_EN);
   wire isRst      = (opcode_q == `FES_OPC_RST);
   wire isSrWrite  = (opcode_q == `FES_OPC_SRW_A) |
                     (opcode_q == `FES_OPC_SRW_B) |
                     (opcode_q == `FES_OPC_SRW_C);
   wire isSecErs   = (opcode_q == `FES_OPC_SEC_ERS);
   wire isSecPrg   = (opcode_q == `FES_OPC_SEC_PRG);
   wire isErase    = (opcode_q == `FES_OPC_ERS_4K) |
                     (opcode_q == `FES_OPC_ERS_32K) |
                     (opcode_q == `FES_OPC_ERS_64K) | isEraseAll;
   wire isPageProg = (opcode_q == `FES_OPC_PAGE_A) |
                     (opcode_q == `FES_OPC_PAGE_B);
   wire isRead     = isWakeId | isMakerId | isIdent | isUid;

   // ----------------------------------------
   // device status
   // ----------------------------------------
   wire write_in_progress_flag       = (state_q == FES_BUSY) |
                    (state_q == FES_SUSPENDING);
   wire susActive = (state_q == FES_SUSPENDING) |
                    (state_q == FES_SUSPENDED);
   wire susProg   = susActive & (kind_q == FES_OPK_PROG);
   wire susErase  = susActive & (kind_q == FES_OPK_SECT);
   wire sleepLike = deepSleep_q | sleepPend_q;
   wire protectOk = ((protectRangeBits == '0) & ~protectComplement) |
                    ((protectRangeBits == `FES_PROT_ALL) &
                     protectComplement); // [RULE5]

   // ----------------------------------------
   // refusal
   // ----------------------------------------
   wire blockInProg  = isSrWrite | isSecErs | isSecPrg | isErase |
                       isPageProg; // [RULE19]
   wire blockInErase = isSrWrite | isSecErs | isErase; // [RULE20]
   wire sleepOk      = isWakeId | isRstEn | isRst;
   wire refused      = opValid_q & (
                       (sleepLike & ~sleepOk) | // [RULE7]
                       wakeBusy_q | // [RULE10]
                       (susProg & blockInProg) | // [RULE19]
                       (susErase & blockInErase) | // [RULE20]
                       (write_in_progress_flag & (isWakeId | isIdent))); // [RULE12] [RULE15]

   // ----------------------------------------
   // execution at end of frame
   // ----------------------------------------
   wire frameEnd  = csRise & opValid_q;
   wire exact8    = (bitCnt_q == `FES_BITS_OPC); // [RULE3]
   wire exec      = frameEnd & exact8 & ~refused;
   wire execErase = exec & isEraseAll & wel_q & protectOk &
                    (state_q == FES_IDLE); // [RULE2] [RULE4]
   wire execSleep = exec & isSleep & ~write_in_progress_flag &
                    (state_q != FES_RESUMING); // [RULE6] [RULE8]
   wire execWake  = frameEnd & isWakeId & sleepLike &
                    ~wakeBusy_q &
                    (bitCnt_q >= `FES_BITS_OPC); // [RULE10]
   wire execSusp  = exec & isSusp & (state_q == FES_BUSY) &
                    ((kind_q == FES_OPK_PROG) |
                     (kind_q == FES_OPK_SECT)); // [RULE17]
   wire execRes   = exec & isRes &
                    (state_q == FES_SUSPENDED); // [RULE21]
   wire execWrEn  = exec & isWrEn;
   wire execWrDis = exec & isWrDis;
   wire execRstEn = exec & isRstEn;
   wire swReset   = exec & isRst & rstArmed_q; // [RULE22]
   wire extGo     = extOpStart & (state_q == FES_IDLE) & wel_q &
                    ~sleepLike & ~wakeBusy_q;

   // ----------------------------------------
   // timers
   // ----------------------------------------
   assign opLoad     = execErase | extGo | swReset;
   assign opLoadVal  = swReset     ? '0 :
                       execErase   ? ERASE_ALL_CYC :
                       extOpIsProg ? PROG_CYC : SECT_CYC;
   assign dlyLoad    = execSleep | execWake | execSusp | execRes |
                       swReset;
   assign dlyLoadVal = swReset   ? '0 :
                       execSleep ? SLEEP_CYC :
                       execWake  ? WAKE_CYC :
                       execSusp  ? SUS_CYC : RESUME_CYC;

   fes_timer uOpTmr (
      .mclk    (mclk),
      .reset   (reset),
      .load    (opLoad),
      .loadVal (opLoadVal),
      .run     (state_q == FES_BUSY),
      .done    (opDone),
      .busy    ()
   );

   fes_timer uDlyTmr (
      .mclk    (mclk),
      .reset   (reset),
      .load    (dlyLoad),
      .loadVal (dlyLoadVal),
      .run     (1'b1),
      .done    (dlyDone),
      .busy    ()
   );

   // ----------------------------------------
   // operation sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      kind_d  = kind_q;
      case (state_q)
         FES_IDLE: begin
            if (execErase) begin
               state_d = FES_BUSY; // [RULE4]
               kind_d  = FES_OPK_CHIP;
            end else if (extGo) begin
               state_d = FES_BUSY;
               kind_d  = extOpIsProg ? FES_OPK_PROG : FES_OPK_SECT;
            end
         end
         FES_BUSY: begin
            if (execSusp) begin
               state_d = FES_SUSPENDING; // [RULE18]
            end else if (opDone) begin
               state_d = FES_IDLE; // [RULE4]
               kind_d  = FES_OPK_NONE;
            end
         end
         FES_SUSPENDING: begin
            if (dlyDone) begin
               state_d = FES_SUSPENDED; // [RULE18]
            end
         end
         FES_SUSPENDED: begin
            if (execRes) begin
               state_d = FES_RESUMING; // [RULE21]
            end
         end
         FES_RESUMING: begin
            if (dlyDone) begin
               state_d = FES_BUSY; // [RULE21]
            end
         end
         default: begin
            state_d = FES_IDLE;
            kind_d  = FES_OPK_NONE;
         end
      endcase
      if (swReset) begin
         state_d = FES_IDLE; // [RULE22]
         kind_d  = FES_OPK_NONE;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= FES_IDLE;
         kind_q  <= FES_OPK_NONE;
      end else begin
         state_q <= state_d;
         kind_q  <= kind_d;
      end
   end

   // ----------------------------------------
   // write enable latch
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         wel_q <= 1'b0;
      end else if (execWrEn) begin
         wel_q <= 1'b1;
      end else if (execWrDis || opLoad) begin
         wel_q <= 1'b0; // [RULE4] [RULE22]
      end
   end

   // ----------------------------------------
   // sleep, wake and reset arming
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset || swReset) begin
         deepSleep_q <= 1'b0; // [RULE9] [RULE22]
         sleepPend_q <= 1'b0;
         wakeBusy_q  <= 1'b0;
      end else if (execSleep) begin
         sleepPend_q <= 1'b1; // [RULE6]
      end else if (execWake) begin
         deepSleep_q <= 1'b0; // [RULE10]
         sleepPend_q <= 1'b0;
         wakeBusy_q  <= 1'b1;
      end else if (dlyDone && sleepPend_q) begin
         deepSleep_q <= 1'b1; // [RULE6]
         sleepPend_q <= 1'b0;
      end else if (dlyDone && wakeBusy_q) begin
         wakeBusy_q <= 1'b0; // [RULE10]
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rstArmed_q <= 1'b0;
      end else if (frameEnd) begin
         rstArmed_q <= execRstEn; // [RULE22]
      end
   end

   // ----------------------------------------
   // identification output
   // ----------------------------------------
   wire [5:0] hdrBits = isIdent ? `FES_BITS_OPC :
                        isUid   ? `FES_HDR_UID : `FES_HDR_ADDR;
   wire [6:0] lastIdx = isWakeId  ? `FES_LAST_WAKE :
                        isMakerId ? `FES_LAST_MAKER :
                        isIdent   ? `FES_LAST_IDENT : `FES_ID_MSB;
   wire [127:0] outVec =
      isWakeId  ? {DEVICE_ID, 120'h0} : // [RULE11]
      isMakerId ? {MAKER_ID, DEVICE_ID, 112'h0} : // [RULE13]
      isIdent   ? {MAKER_ID, MEM_TYPE, CAPACITY, 104'h0} : // [RULE14]
                  UNIQUE_ID; // [RULE16]
   wire outGo  = fall & opValid_q & isRead & ~refused &
                 (bitCnt_q >= hdrBits);
   wire outBit = outVec[`FES_ID_MSB - outIdx_q];
   wire idxEnd = (outIdx_q == lastIdx);

   always_ff @(posedge mclk) begin
      if (reset || csFall || csRise) begin
         so_q     <= 1'b0;
         soOe_q   <= 1'b0;
         outIdx_q <= '0;
      end else if (outGo) begin
         so_q     <= outBit; // [RULE11] [RULE14]
         soOe_q   <= 1'b1;
         outIdx_q <= idxEnd ? '0 : outIdx_q + 7'h01;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign so                  = so_q;
   assign soOe                = soOe_q;
   assign frameOpcode         = opcode_q;
   assign frameOpcodeValid    = opValid_q;
   assign frameRefused        = refused;
   assign writeInProgressFlag = write_in_progress_flag;
   assign writeEnableLatch    = wel_q;
   assign suspendFlags        = {susErase, susProg}; // [RULE18]
   assign deepSleep           = deepSleep_q;
   assign wakeBusy            = wakeBusy_q;
   assign chipEraseGo         = execErase;

endmodule : fes_cmd_core

// File: testbench/fes_cmd_core_properties.sv
`timescale 1ns/1ps
module fes_cmd_core_properties (
   // clock and reset
   input wire logic       mclk,
   input wire logic       reset,
   // watched ports
   input wire logic [2:0] protectRangeBits,
   input wire logic       protectComplement,
   input wire logic [7:0] frameOpcode,
   input wire logic       frameOpcodeValid,
   input wire logic       frameRefused,
   input wire logic       writeInProgressFlag,
   input wire logic       writeEnableLatch,
   input wire logic [1:0] suspendFlags,
   input wire logic       deepSleep,
   input wire logic       wakeBusy,
   input wire logic       chipEraseGo
);
   localparam int SusMax = 1000;
   logic protOff;
   assign protOff = (protectRangeBits == 3'h0 && !protectComplement)
                 || (protectRangeBits == 3'h7 && protectComplement);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_ceStart; ##1 (writeInProgressFlag && !writeEnableLatch);
   endsequence
   sequence s_wake; wakeBusy [*8]; endsequence
   property p_ceKind; chipEraseGo |-> frameOpcode inside {8'h60, 8'hc7};
   endproperty
   a_ceKind: assert property (p_ceKind) else $error("bad erase op");
   property p_ceGuard; chipEraseGo |-> writeEnableLatch && protOff; endproperty
   a_ceGuard: assert property (p_ceGuard) else $error("erase unguarded");
   property p_ceRun; chipEraseGo |-> s_ceStart; endproperty
   a_ceRun: assert property (p_ceRun) else $error("erase flags wrong");
   property p_pwrUp;
      $fell(reset) |-> !deepSleep && !writeInProgressFlag && suspendFlags == 2'h0;
   endproperty
   a_pwrUp: assert property (p_pwrUp) else $error("not standby");
   property p_busyAwake; writeInProgressFlag |-> !deepSleep; endproperty
   a_busyAwake: assert property (p_busyAwake) else $error("slept busy");
   property p_busyId; writeInProgressFlag && frameOpcodeValid
      && frameOpcode inside {8'hab, 8'h9f} |-> frameRefused; endproperty
   a_busyId: assert property (p_busyId) else $error("id taken busy");
   property p_wake; $fell(deepSleep) && frameOpcode == 8'hab |-> s_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake delay");
   property p_susRef; suspendFlags[0] && frameOpcodeValid && frameOpcode inside
      {8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
       8'h02, 8'h32} |-> frameRefused; endproperty
   a_susRef: assert property (p_susRef) else $error("cmd not refused");
   property p_susDrop;
      $rose(|suspendFlags) |-> ##[0:SusMax] !writeInProgressFlag;
   endproperty
   a_susDrop: assert property (p_susDrop) else $error("busy stuck");
   property p_resume; $fell(|suspendFlags) && frameOpcode == 8'h7a
      |-> ##[0:11] writeInProgressFlag; endproperty
   a_resume: assert property (p_resume) else $error("resume late");
endmodule : fes_cmd_core_properties
bind fes_cmd_core fes_cmd_core_properties i_props (.mclk, .reset,
   .protectRangeBits, .protectComplement, .frameOpcode, .frameOpcodeValid,
   .frameRefused, .writeInProgressFlag, .writeEnableLatch, .suspendFlags,
   .deepSleep, .wakeBusy, .chipEraseGo);

// File: testbench/fes_spi_host.sv
`timescale 1ns/1ps
module fes_spi_host (
   // clock
   input wire logic     mclk,
   // serial pins
   output logic         csN,
   output logic         sclk,
   output logic         si,
   input wire logic     so,
   // captured read data
   output logic         rxDone,
   output logic [127:0] rxData
);
   initial begin
      csN = 1'b1; sclk = 1'b0; si = 1'b0; rxDone = 1'b0; rxData = '0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // opcode, hdr zero bits, then rd bits captured
   task automatic xfer(input logic [7:0] opc, input int hdr, input int rd);
      tick(1);
      csN <= 1'b0;
      rxData <= '0;
      for (int i = 0; i < 8 + hdr + rd; i++) begin
         si <= (i < 8) ? opc[7-i] : (i < 8 + hdr) ? 1'b0 : ~si;
         tick(5);
         if (i >= 8 + hdr) rxData <= {rxData[126:0], so};
         sclk <= 1'b1;
         tick(3);
         sclk <= 1'b0;
      end
      tick(5);
      csN <= 1'b1;
      si <= ~si;
      rxDone <= (rd > 0);
      tick(1);
      rxDone <= 1'b0;
      tick(5);
   endtask : xfer
endmodule : fes_spi_host

// File: testbench/fes_cmd_core_bench.sv
`timescale 1ns/1ps
module fes_cmd_core_bench;
   import fes_pkg::*;
   // identity values, arbitrary
   localparam logic [31:0]  Ids = 32'h9e2d4c71;
   localparam logic [127:0] Uid = {4{32'h13579bdf}};
   logic mclk = 1'b0, reset = 1'b1, cmp = 1'b0, opGo = 1'b0, opPrg = 1'b0;
   logic [2:0] prot = 3'h0;
   logic csN, sclk, si, so, rxDone, write_in_progress_flag, write_enable_latch, slp, wkb, rf;
   logic [1:0] sus;
   logic [127:0] rxData, expQ[$];
   logic [4:0] st;
   int failures = 0, cmp_count = 0;
   assign st = {write_in_progress_flag, write_enable_latch, sus, slp};
   initial forever #10 mclk = ~mclk;
   fes_cmd_core #(.ERASE_ALL_CYC(600), .PROG_CYC(2000), .SECT_CYC(2000),
      .MAKER_ID(Ids[31:24]), .MEM_TYPE(Ids[23:16]), .CAPACITY(Ids[15:8]),
      .DEVICE_ID(Ids[7:0]), .UNIQUE_ID(Uid)) i_fes_cmd_core (.mclk(mclk),
      .reset(reset), .csN(csN), .sclk(sclk), .si(si), .so(so), .soOe(),
      .protectRangeBits(prot), .protectComplement(cmp), .extOpStart(opGo),
      .extOpIsProg(opPrg), .frameOpcode(), .frameOpcodeValid(),
      .frameRefused(rf), .writeInProgressFlag(write_in_progress_flag), .writeEnableLatch(write_enable_latch),
      .suspendFlags(sus), .deepSleep(slp), .wakeBusy(wkb), .chipEraseGo());
   fes_spi_host i_fes_spi_host (.mclk(mclk), .csN(csN), .sclk(sclk),
      .si(si), .so(so), .rxDone(rxDone), .rxData(rxData));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic cmd(input logic [7:0] op, input int hdr);
      i_fes_spi_host.xfer(op, hdr, 0);
   endtask : cmd
   task automatic rd(input logic [7:0] op, input int h, input int n,
                     input logic [127:0] e);
      expQ.push_back(e);
      i_fes_spi_host.xfer(op, h, n);
   endtask : rd
   task automatic waitIdle(input int n);
      while (write_in_progress_flag !== 1'b0 && n > 0) begin
         tick(1);
         n--;
      end
      if (write_in_progress_flag !== 1'b0) begin
         failures++;
         tally_and_finish();
      end
   endtask : waitIdle
   always @(posedge mclk) begin
      if (rxDone === 1'b1) chk(rxData, expQ.pop_front());
   end
   initial begin
      void'($urandom(32'hc79ac2fd));
      tick(12);
      reset <= 1'b0;
      tick(3);
      chk(st, 5'h00);
      rd(8'h9f, 0, 24, Ids[31:8]);
      rd(8'h90, 24, 16, {Ids[31:24], Ids[7:0]});
      rd(8'hab, 24, 16, {2{Ids[7:0]}});
      rd(8'h4b, 32, 128, Uid);
      $display("test id reads done");
      cmd(8'h60, 0);
      chk(st, 5'h00);
      cmd(8'h06, 0);
      cmd(8'h60, 1);
      chk(st, 5'h08);
      prot <= 3'h1 + 3'($urandom % 6);
      cmp <= 1'($urandom);
      cmd(8'h60, 0);
      chk(st, 5'h08);
      for (int k = 0; k < 2; k++) begin
         prot <= k ? 3'h7 : 3'h0;
         cmp <= 1'(k);
         cmd(8'h06, 0);
         cmd(k ? 8'hc7 : 8'h60, 0);
         chk(st, 5'h10);
         cmd(8'hab, 0);
         cmd(8'h9f, 0);
         cmd(8'hb9, 0);
         tick(160);
         chk(st, 5'h10);
         waitIdle(800);
         chk(st, 5'h00);
      end
      $display("test whole erase done");
      cmd(8'hb9, 0);
      tick(160);
      chk(st, 5'h01);
      cmd(8'h06, 0);
      chk(st, 5'h01);
      cmd(8'hab, 0);
      chk({st, wkb}, 6'h01);
      tick(160);
      $display("test sleep done");
      cmd(8'h75, 0);
      chk(st, 5'h00);
      for (int k = 0; k < 2; k++) begin
         cmd(8'h06, 0);
         opGo <= 1'b1;
         opPrg <= 1'(k);
         tick(1);
         opGo <= 1'b0;
         cmd(8'h75, 0);
         chk(sus, k ? 2'h1 : 2'h2);
         waitIdle(1100);
         cmd(8'h06, 0);
         cmd(8'h60, 0);
         chk({write_in_progress_flag, rf}, 2'h1);
         cmd(8'h7a, 0);
         tick(10);
         chk({write_in_progress_flag, sus}, 3'h4);
         cmd(8'h66, 0);
         cmd(8'h99, 0);
         chk(st, 5'h00);
      end
      $display("test suspend done");
      tally_and_finish();
   end
endmodule : fes_cmd_core_bench
